/* common/fc_pkg.sv */
package fc_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS      = 35;
  localparam int RECOV_NS      = 10;
  localparam int SYNC_STAGES   = 2;
  localparam int PULSE_CYC     =
    (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOV_CYC     =
    (RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // read data pass the synchroniser before capture
  localparam int RD_LOW_CYC    = PULSE_CYC + SYNC_STAGES;
  localparam logic [3:0] PULSE_CNT  = 4'(PULSE_CYC - 1);
  localparam logic [3:0] RECOV_CNT  = 4'(RECOV_CYC - 1);
  localparam logic [3:0] RD_LOW_CNT = 4'(RD_LOW_CYC - 1);
  localparam int WORD_W = 9;
  localparam int DEPTH  = 512;
  localparam logic [9:0] DEPTH_CNT = 10'(DEPTH);
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_WDATA  = 8'h04;
  localparam logic [7:0] OFF_RDATA  = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_CFG    = 8'h10;
  localparam int CMD_WR     = 0;
  localparam int CMD_RD     = 1;
  localparam int CMD_INIT   = 2;
  localparam int CMD_REPLAY = 3;
  localparam int CMD_LOAD   = 4;
  localparam int CFG_EXPAND  = 0;
  localparam int CFG_FIRST   = 1;
  localparam int CFG_LOAD_IN = 2;
  localparam logic [2:0] CFG_RESET = 3'h2;
  localparam int STA_WBUSY  = 0;
  localparam int STA_RBUSY  = 1;
  localparam int STA_SBUSY  = 2;
  localparam int STA_EMPTY  = 3;
  localparam int STA_FULL   = 4;
  localparam int STA_THIRD  = 5;
  localparam int STA_RVALID = 6;
  localparam int STA_RETX   = 7;
  localparam int SY_EMPTY = 9;
  localparam int SY_FULL  = 10;
  localparam int SY_THIRD = 11;
  localparam int SY_XO    = 12;
  localparam int SYNC_W   = 13;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'h1, ENG_LOW = 3'h2, ENG_REC = 3'h4
  } fc_eng_t;
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01, SEQ_INIT = 5'h02, SEQ_REPLAY = 5'h04,
    SEQ_LOAD = 5'h08, SEQ_REC = 5'h10
  } fc_seq_t;
endpackage

/* common/fc_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface fc_sync_if #(parameter int W = 13);
  logic [W-1:0] q;
  modport src (output q);
  modport dst (input q);
endinterface
`default_nettype wire

/* core/fc_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fc_pin_sync #(
  parameter int W = 13
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] raw,
  fc_sync_if.src            sy
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fc_sync_st_t;

  fc_sync_st_t s;
  fc_sync_st_t n;

  // first stage feeds only the second stage
  always_comb begin
    n    = s;
    n.s1 = raw;
    n.s2 = s.s1;
    if (sys_rst) begin
      n = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= n;
  end

  assign sy.q = s.s2;
endmodule // fc_pin_sync
`default_nettype wire

/* core/fc_ctrl.sv */
// Summary of operation
// R1 - device stores input word while write strobe low, advances after rise
// R2 - device drives oldest stored word while read strobe is low
// R3 - read pointer advances on read strobe rise; next read gets next word
// R4 - device output lines float whenever read strobe is high
// R5 - init pulse clears pointers and flag registers, device becomes empty
// R6 - device addresses internally; no address given, order is kept
// R7 - write and read sides run independently at their own rates
// R8 - stand-alone: expansion_in held low by the surrounding system
// R9 - chained: expansion_in follows the previous device's expansion_out
// R10 - replay pin low re-delivers read data, stand-alone mode only
// R11 - during load replay pin low loads via output lines, high via inputs
// R12 - chained: replay pin low on first device, high on the others
// R13 - input words go to array on write, flag registers on load
// R14 - empty output is empty when unconfigured, near-empty once configured
// R15 - unconfigured device gives empty, full and half-full flags
// R16 - configured device gives near-empty and near-full, own offsets each; fc_dev_model uses one loaded offset for both
// R17 - configured third flag is half-full or full/empty by config bit
// R18 - initialise by pulsing init low with both strobes held high
// R19 - device ignores writes while full, stored words unchanged
// R20 - device ignores reads while empty, outputs stay floating
// R21 - replay rewinds read pointer only; valid below 512 writes since init
`timescale 1ns/1ps
`default_nettype none
module fc_ctrl
  import fc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  output logic                   init_pulse_n,
  output logic                   write_strobe_n,
  output logic                   read_strobe_n,
  output logic [WORD_W-1:0]      write_word_lines,
  input  wire logic [WORD_W-1:0] read_word_lines_i,
  output logic [WORD_W-1:0]      read_word_lines_o,
  output logic                   read_word_lines_oe,
  output logic                   replay_or_load_side_pin,
  output logic                   expansion_in,
  input  wire logic              prev_expansion_out_n,
  input  wire logic              empty_or_near_empty_out_n,
  input  wire logic              full_flag_n,
  input  wire logic              half_full_flag_n
);
  typedef struct packed {
    fc_seq_t          seq;
    fc_eng_t          we;
    fc_eng_t          re;
    logic [3:0]       sc;
    logic [3:0]       wc;
    logic [3:0]       rc;
    logic [9:0]       nwr;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] rdata;
    logic             rvalid;
    logic [2:0]       cfg;
    logic             init_n;
    logic             wr_n;
    logic             rd_n;
    logic             replay;
    logic             xi;
    logic             oe;
    logic [WORD_W-1:0] wl;
    logic [WORD_W-1:0] ql;
    logic             ap_wr;
    logic             ap_rd;
    logic [7:0]       ap_addr;
    logic             ready;
    logic             resp;
    logic [31:0]      rdw;
  } fc_st_t;

  localparam fc_st_t ST_RST = '{seq: SEQ_IDLE, we: ENG_IDLE,
    re: ENG_IDLE, cfg: CFG_RESET, init_n: 1'b1, wr_n: 1'b1,
    rd_n: 1'b1, replay: 1'b1, ready: 1'b1, default: '0};

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  fc_st_t            s;
  fc_st_t            n;
  logic              ap;
  logic              wr_go;
  logic              rd_go;
  logic              pin_idle;
  logic [4:0]        cmd;
  logic [31:0]       stat;

  fc_sync_if #(.W(SYNC_W)) sy ();

  fc_pin_sync #(.W(SYNC_W)) u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .raw      ({prev_expansion_out_n, half_full_flag_n, full_flag_n,
                empty_or_near_empty_out_n, read_word_lines_i}),
    .sy       (sy.src)
  );

  always_comb begin
    n       = s;
    n.resp  = 1'b0;
    n.ready = 1'b1;
    stat    = '0;
    // R14 R15 R16 R17 flags seen as status
    stat[STA_WBUSY]  = s.we != ENG_IDLE;
    stat[STA_RBUSY]  = s.re != ENG_IDLE;
    stat[STA_SBUSY]  = s.seq != SEQ_IDLE;
    stat[STA_EMPTY]  = sy.q[SY_EMPTY];
    stat[STA_FULL]   = sy.q[SY_FULL];
    stat[STA_THIRD]  = sy.q[SY_THIRD];
    stat[STA_RVALID] = s.rvalid;
    stat[STA_RETX]   = s.nwr < DEPTH_CNT;
    ap = hsel && htrans[1] && hready && hsize == 3'h2;
    n.ap_wr   = ap && hwrite;
    n.ap_rd   = ap && !hwrite;
    n.ap_addr = haddr[7:0];
    // one wait state lets read data leave a register
    if (ap && !hwrite) begin
      n.ready = 1'b0;
    end
    if (s.ap_rd) begin
      n.rdw = '0;
      if (hit(s.ap_addr, OFF_WDATA)) begin
        n.rdw[WORD_W-1:0] = s.wdata;
      end
      if (hit(s.ap_addr, OFF_RDATA)) begin
        n.rdw[WORD_W-1:0] = s.rdata;
        n.rvalid = 1'b0;
      end
      if (hit(s.ap_addr, OFF_STATUS)) begin
        n.rdw = stat;
      end
      if (hit(s.ap_addr, OFF_CFG)) begin
        n.rdw[2:0] = s.cfg;
      end
    end
    cmd = (s.ap_wr && hit(s.ap_addr, OFF_CMD)) ? hwdata[4:0] : 5'h00;
    if (s.ap_wr && hit(s.ap_addr, OFF_WDATA)) begin
      n.wdata = hwdata[WORD_W-1:0];
    end
    if (s.ap_wr && hit(s.ap_addr, OFF_CFG)) begin
      n.cfg = hwdata[2:0];
    end
    // R7 separate engines
    wr_go = cmd[CMD_WR] && s.we == ENG_IDLE && s.seq == SEQ_IDLE;
    rd_go = cmd[CMD_RD] && s.re == ENG_IDLE && s.seq == SEQ_IDLE;
    // R1 R6 R13 word held across rising edge
    case (s.we)
      ENG_IDLE: begin
        if (wr_go) begin
          n.we   = ENG_LOW;
          n.wr_n = 1'b0;
          n.wl   = s.wdata;
          n.wc   = PULSE_CNT;
        end
      end
      ENG_LOW: begin
        n.wc = s.wc - 4'h1;
        if (s.wc == 4'h0) begin
          n.we   = ENG_REC;
          n.wr_n = 1'b1;
          n.wc   = RECOV_CNT;
          if (s.nwr != DEPTH_CNT) begin
            n.nwr = s.nwr + 10'h001;
          end
        end
      end
      ENG_REC: begin
        n.wc = s.wc - 4'h1;
        if (s.wc == 4'h0) begin
          n.we = ENG_IDLE;
        end
      end
      default: n.we = ENG_IDLE;
    endcase
    // R2 R3 R4 capture before strobe rises
    case (s.re)
      ENG_IDLE: begin
        if (rd_go) begin
          n.re   = ENG_LOW;
          n.rd_n = 1'b0;
          n.rc   = RD_LOW_CNT;
        end
      end
      ENG_LOW: begin
        n.rc = s.rc - 4'h1;
        if (s.rc == 4'h0) begin
          n.re     = ENG_REC;
          n.rd_n   = 1'b1;
          n.rc     = RECOV_CNT;
          n.rdata  = sy.q[WORD_W-1:0];
          n.rvalid = 1'b1;
        end
      end
      ENG_REC: begin
        n.rc = s.rc - 4'h1;
        if (s.rc == 4'h0) begin
          n.re = ENG_IDLE;
        end
      end
      default: n.re = ENG_IDLE;
    endcase
    case (s.seq)
      SEQ_IDLE: begin
        if (s.we == ENG_IDLE && s.re == ENG_IDLE && !wr_go && !rd_go) begin
          // R5 R18 init with both strobes high
          if (cmd[CMD_INIT]) begin
            n.seq    = SEQ_INIT;
            n.init_n = 1'b0;
            n.sc     = PULSE_CNT;
          // R10 R21 replay guarded
          end else if (cmd[CMD_REPLAY] && !s.cfg[CFG_EXPAND] &&
                       s.nwr < DEPTH_CNT) begin
            n.seq    = SEQ_REPLAY;
            n.replay = 1'b0;
            n.sc     = PULSE_CNT;
          // R11 R13 load side select
          end else if (cmd[CMD_LOAD]) begin
            n.seq    = SEQ_LOAD;
            n.init_n = 1'b0;
            n.wr_n   = 1'b0;
            n.replay = s.cfg[CFG_LOAD_IN];
            n.oe     = !s.cfg[CFG_LOAD_IN];
            n.wl     = s.wdata;
            n.ql     = s.wdata;
            n.sc     = PULSE_CNT;
          end
        end
      end
      SEQ_INIT, SEQ_REPLAY, SEQ_LOAD: begin
        n.sc = s.sc - 4'h1;
        if (s.sc == 4'h0) begin
          if (s.seq != SEQ_REPLAY) begin
            n.nwr = '0;
          end
          n.seq    = SEQ_REC;
          n.init_n = 1'b1;
          n.wr_n   = 1'b1;
          n.oe     = 1'b0;
          n.sc     = RECOV_CNT;
        end
      end
      SEQ_REC: begin
        n.sc = s.sc - 4'h1;
        if (s.sc == 4'h0) begin
          n.seq = SEQ_IDLE;
        end
      end
      default: n.seq = SEQ_IDLE;
    endcase
    // R12 chain position level
    pin_idle = s.cfg[CFG_EXPAND] ? !s.cfg[CFG_FIRST] : 1'b1;
    if (n.seq == SEQ_IDLE || n.seq == SEQ_REC) begin
      n.replay = pin_idle;
    end
    // R8 R9 expansion input source
    n.xi = s.cfg[CFG_EXPAND] ? sy.q[SY_XO] : 1'b0;
    if (sys_rst) begin
      n = ST_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    s <= n;
  end

  assign hreadyout               = s.ready;
  assign hrdata                  = s.rdw;
  assign hresp                   = s.resp;
  assign init_pulse_n            = s.init_n;
  assign write_strobe_n          = s.wr_n;
  assign read_strobe_n           = s.rd_n;
  assign write_word_lines        = s.wl;
  assign read_word_lines_o       = s.ql;
  assign read_word_lines_oe      = s.oe;
  assign replay_or_load_side_pin = s.replay;
  assign expansion_in            = s.xi;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_init_strobes_high: assert property ( // R18
    s.seq == SEQ_INIT |-> s.wr_n && s.rd_n)
    else $error("init pulse with a strobe low");
  a_init_pulse_width: assert property ( // R5
    $fell(s.init_n) |-> (!s.init_n) [*5] ##1 s.init_n)
    else $error("init pulse width wrong");
  a_xi_alone_low: assert property ( // R8
    !s.cfg[CFG_EXPAND] |=> !s.xi)
    else $error("expansion_in not low when alone");
  a_xi_chain_follow: assert property ( // R9
    s.cfg[CFG_EXPAND] |=> s.xi == $past(sy.q[SY_XO]))
    else $error("expansion_in not following chain");
  a_replay_alone_only: assert property ( // R10
    $fell(s.replay) && s.seq == SEQ_REPLAY |->
      (!s.cfg[CFG_EXPAND] && !s.replay) [*5] ##1 s.replay)
    else $error("replay pulse wrong or in chain");
  a_chain_pin_level: assert property ( // R12
    s.cfg[CFG_EXPAND] && s.seq == SEQ_IDLE &&
      $past(s.seq) == SEQ_IDLE && $stable(s.cfg) |->
      s.replay == !s.cfg[CFG_FIRST])
    else $error("chain position level wrong");
  a_read_independent: assert property ( // R7
    rd_go && s.we != ENG_IDLE |=> !s.rd_n)
    else $error("read held back by write");
  a_read_capture: assert property ( // R2
    $rose(s.rd_n) && s.re == ENG_REC |->
      s.rvalid && s.rdata == $past(sy.q[WORD_W-1:0]))
    else $error("read word not captured");
  a_load_side_sel: assert property ( // R11
    s.seq == SEQ_LOAD && $past(s.seq) == SEQ_IDLE |->
      s.replay == $past(s.cfg[CFG_LOAD_IN]) && s.oe == !s.replay)
    else $error("load side select wrong");

  c_write_done: cover property ($rose(s.wr_n) && s.we == ENG_REC);
  c_read_done: cover property ($rose(s.rd_n) && s.re == ENG_REC);
  c_replay: cover property (s.seq == SEQ_REPLAY);
  c_overlap: cover property (!s.wr_n && !s.rd_n);
endmodule // fc_ctrl
`default_nettype wire

/* tb/fc_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fc_dev_model (
  input  wire logic       init_pulse_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic [8:0] d,
  input  wire logic [8:0] q_in,
  output logic      [8:0] q,
  output logic            q_oe,
  input  wire logic       side_pin,
  input  wire logic       exp_in,
  output logic            empty_n,
  output logic            full_n,
  output logic            third_n,
  output logic            exp_out_n
);
  logic [8:0] mem [0:511];
  logic [8:0] lw;
  int         wp = 0, rp = 0, cnt, off = 0;
  logic       cfg = 1'b0, fe_sel = 1'b0, ld = 1'b0, wr_ok, rd_ok;
  assign exp_out_n = 1'b1;
  always @(negedge init_pulse_n) begin
    wp = 0;
    rp = 0;
    cfg = 1'b0;
    fe_sel = 1'b0;
    off = 0;
  end
  // load path choice
  // taken once the pins settle; the release edge would race the lines
  always @(negedge write_strobe_n) begin
    #1;
    if (!init_pulse_n) begin
      ld = 1'b1;
      lw = side_pin ? d : q_in;
    end
  end
  always @(negedge write_strobe_n) wr_ok = full_n;
  always @(posedge write_strobe_n) begin
    if (ld) begin
      ld = 1'b0;
      cfg = 1'b1;
      off = int'(lw[5:0]);
      fe_sel = lw[8];
    end else if (wr_ok) begin
      mem[wp % 512] = d;
      wp++;
    end
  end
  always @(negedge read_strobe_n) begin
    rd_ok = (wp - rp) > 0;
    if (rd_ok) begin
      q = mem[rp % 512];
      q_oe = 1'b1;
    end
  end
  always @(posedge read_strobe_n) begin
    q_oe = 1'b0;
    if (rd_ok) rp++;
  end
  always @(negedge side_pin) begin
    if (init_pulse_n && !exp_in) rp = 0;
  end
  always @* begin
    cnt = wp - rp;
    empty_n = cnt > (cfg ? off : 0);
    full_n = cnt < 512 - (cfg ? off : 0);
    third_n = (cfg && fe_sel) ? (cnt > 0 && cnt < 512) : (cnt <= 256);
  end
  initial q_oe = 1'b0;
endmodule // fc_dev_model
`default_nettype wire

/* tb/tb_fc_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_fc_ctrl;
  import fc_pkg::*;
  logic        core_clk, sys_rst, hsel, hwrite, hready, hresp, rdy_n;
  logic        hrs_n, pxo;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, hrd_n, rd;
  logic        ipn, wsn, rsn, h_oe, d_oe, pin, xin, efn, ffn, tfn, xon;
  logic [8:0]  wl, h_q, d_q, flt, lines;
  int          n_mismatch, cmp_count;
  assign lines = h_oe ? h_q : (d_oe ? d_q : flt);
  fc_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .init_pulse_n(ipn),
    .write_strobe_n(wsn), .read_strobe_n(rsn), .write_word_lines(wl),
    .read_word_lines_i(lines), .read_word_lines_o(h_q),
    .read_word_lines_oe(h_oe), .replay_or_load_side_pin(pin),
    .expansion_in(xin), .prev_expansion_out_n(pxo),
    .empty_or_near_empty_out_n(efn), .full_flag_n(ffn),
    .half_full_flag_n(tfn));
  fc_dev_model i_dev (.init_pulse_n(ipn), .write_strobe_n(wsn),
    .read_strobe_n(rsn), .d(wl), .q_in(lines), .q(d_q), .q_oe(d_oe),
    .side_pin(pin), .exp_in(xin), .empty_n(efn), .full_n(ffn),
    .third_n(tfn), .exp_out_n(xon));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // values seen here stand at the next rising edge
  always @(negedge core_clk) begin
    rdy_n <= hready;
    hrd_n <= hrdata;
    hrs_n <= hresp;
    flt <= ~flt;
  end
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge core_clk);
    while (rdy_n !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge core_clk);
    while (rdy_n !== 1'b1) @(posedge core_clk);
    rd = hrd_n;
    chk({31'h0, hrs_n}, 32'h0);
  endtask
  task automatic cmd(input int b);
    bus(1'b1, OFF_CMD, 32'h1 << b);
    bus(1'b0, OFF_STATUS, 32'h0);
    for (int k = 0; k < 40 && rd[2:0] !== 3'b000; k++)
      bus(1'b0, OFF_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h0);
  endtask
  task automatic wr(input logic [8:0] w);
    bus(1'b1, OFF_WDATA, {23'h0, w});
    cmd(CMD_WR);
  endtask
  task automatic rdw(input logic [8:0] e);
    cmd(CMD_RD);
    bus(1'b0, OFF_RDATA, 32'h0);
    chk(rd, {23'h0, e});
  endtask
  // flags as {third_n, full_n, empty_n}
  task automatic sta(input logic [2:0] e);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk({29'h0, rd[5:3]}, {29'h0, e});
  endtask
  initial begin
    #800000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pxo = 1'b1;
    flt = 9'h0a5;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(1'b0, OFF_CFG, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    cmd(CMD_INIT);
    sta(3'b110);
    for (int i = 0; i < 4; i++) wr(9'h1a0 + 9'(i));
    sta(3'b111);
    rdw(9'h1a0);
    rdw(9'h1a1);
    cmd(CMD_REPLAY);
    for (int i = 0; i < 4; i++) rdw(9'h1a0 + 9'(i));
    cmd(CMD_RD);
    wr(9'h05a);
    rdw(9'h05a);
    cmd(CMD_INIT);
    for (int i = 0; i < 512; i++) begin
      wr(9'(i) ^ 9'h0c3);
      if (i == 256) sta(3'b011);
    end
    sta(3'b001);
    chk({31'h0, rd[STA_RETX]}, 32'h0);
    wr(9'h1ff);
    for (int i = 0; i < 512; i++) rdw(9'(i) ^ 9'h0c3);
    sta(3'b110);
    for (int j = 0; j < 2; j++) begin
      bus(1'b1, OFF_CFG, (j == 0) ? 32'h4 : 32'h0);
      bus(1'b1, OFF_WDATA, (j == 0) ? 32'h104 : 32'h004);
      cmd(CMD_LOAD);
      sta((j == 0) ? 3'b010 : 3'b110);
    end
    for (int i = 0; i < 3; i++) wr(9'(i));
    sta(3'b110);
    wr(9'h011);
    wr(9'h012);
    sta(3'b111);
    // read issued while the write engine is still busy
    bus(1'b1, OFF_WDATA, 32'h0ab);
    bus(1'b1, OFF_CMD, 32'h1 << CMD_WR);
    rdw(9'h000);
    bus(1'b1, OFF_CFG, 32'h1);
    repeat (5) @(negedge core_clk);
    chk({30'h0, pin, xin}, 32'h3);
    bus(1'b1, OFF_CFG, 32'h3);
    repeat (4) @(negedge core_clk);
    chk({30'h0, pin, xin}, 32'h1);
    @(posedge core_clk);
    pxo <= 1'b0;
    repeat (5) @(negedge core_clk);
    chk({30'h0, pin, xin}, 32'h0);
    stop_test();
  end
endmodule // tb_fc_ctrl
`default_nettype wire
